// [logic/asr_trigger_consts.vh]
/*
 * Named constants for the converter trigger and modulator source router.
 * Assumes inclusion by the router and its verification files; definitions only.
 */
`ifndef ASR_TRIGGER_CONSTS_VH
`define ASR_TRIGGER_CONSTS_VH

// ----------------------------------------------------------------------------
// Routing control field positions
// ----------------------------------------------------------------------------
`define ASR_CTL_WIDTH 4
`define ASR_CTL_RELOAD_BIT 0
`define ASR_CTL_MASTER_EN_BIT 1
`define ASR_CTL_SECOND_EN_BIT 2
`define ASR_CTL_SPARE_BIT 3
`define ASR_CTL_RESET 4'h0
`define ASR_TRIG_RESET 1'h0

// ----------------------------------------------------------------------------
// Converter modes
// ----------------------------------------------------------------------------
`define ASR_MODE_WIDTH 2
`define ASR_MODE_SEQUENTIAL 2'h0
`define ASR_MODE_PARALLEL 2'h1
`define ASR_MODE_PAR_INDEP 2'h2

// ----------------------------------------------------------------------------
// Modulator output source selection, one two-bit code per output pair
// ----------------------------------------------------------------------------
`define ASR_PAIRS 3
`define ASR_SRC_WIDTH 2
`define ASR_SRC_GENERATOR 2'h0
`define ASR_SRC_GPIO 2'h1
`define ASR_SRC_TIMER 2'h2
`define ASR_SRC_LIMIT 2'h3
`define ASR_PAIR_WIDTH 2
`define ASR_PAIR_RESET 2'h0
`define ASR_PAIR_HIGH 2'h1
`define ASR_PAIR_LOW 2'h2

`endif

// [logic/asr_sync2.v]
/*
 * Two flip-flop synchroniser for a bus of levels.
 * Assumes the inputs are from outside the clock domain.
 */
`timescale 1ns/1ps

module asr_sync2 #(
    parameter WIDTH = 1
) (
    input wire clock,
    input wire rst_n,
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage1_reg <= {WIDTH{1'h0}};
            stage2_reg <= {WIDTH{1'h0}};
        end else begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;

endmodule

// [logic/asr_trigger_router.v]
/*
 * Trigger router between the modulator, timer module A and the two converters,
 * plus the source selection for the modulator output pairs.
 * The reload pulse can stand in for the ordinary input of timer channel 3;
 * timer channels 3 and 2 become the master and secondary converter triggers,
 * gated by the routing control, with the converter mode gating the starts; each modulator
 * output pair takes its level from the generator, a pin, a timer output or
 * the converter limit comparisons, as chosen per pair.
 * Assumes peripheral signals share the clock; general-purpose pin inputs are
 * asynchronous and are synchronised here. Control comes from the system
 * integration unit as plain levels on the same clock. Triggers, start strobes
 * and pair levels are registered and appear one clock after their cause; a
 * pin reaches its pair three clocks after it changes.
 */
// Behaviour
// RULE_01 - Selectable reload pulse into timer channel 3
// RULE_02 - Timer channel 3 drives master trigger
// RULE_03 - Timer channel 2 drives secondary trigger
// RULE_04 - Master trigger starts both converters, sequential/parallel
// RULE_05 - Secondary trigger starts converter B, independent only
// RULE_06 - Integration unit control bits govern routing
// RULE_07 - Limits, timers, pins steer modulator outputs
// RULE_08 - Active-low signals asserted when low
// RULE_09 - Unselected reload leaves channel 3 ordinary input
`timescale 1ns/1ps
`include "asr_trigger_consts.vh"

module asr_trigger_router (
    input wire clock,
    input wire rst_n,
    input wire [`ASR_CTL_WIDTH-1:0] routeCtl,
    input wire [`ASR_MODE_WIDTH-1:0] convMode,
    input wire [`ASR_PAIRS*`ASR_SRC_WIDTH-1:0] pairSrcSel,
    input wire modReloadPulse,
    input wire timerCh3OrdinaryIn,
    input wire timerCh2Out,
    input wire timerCh3Out,
    input wire [`ASR_PAIRS-1:0] converterOverLimit,
    input wire [`ASR_PAIRS-1:0] converterUnderLimit,
    input wire [`ASR_PAIRS-1:0] gpioPinIn,
    input wire [`ASR_PAIRS-1:0] timerPairOut,
    input wire [2*`ASR_PAIRS-1:0] generatorOut,
    output wire timerCh3In,
    output wire masterConvTrigger,
    output wire secondaryConvTrigger,
    output wire converterAStart,
    output wire converterBStart,
    output wire [2*`ASR_PAIRS-1:0] modOut
);

    // ------------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------------
    // Sequential and parallel modes let a master trigger start both converters.
    function startsBoth;
        input [`ASR_MODE_WIDTH-1:0] mode;
        begin
            if (mode == `ASR_MODE_SEQUENTIAL) begin
                startsBoth = 1'h1;
            end else if (mode == `ASR_MODE_PARALLEL) begin
                startsBoth = 1'h1;
            end else begin
                startsBoth = 1'h0;
            end
        end
    endfunction

    // Only parallel independent mode lets a secondary trigger start converter B.
    function startsSecond;
        input [`ASR_MODE_WIDTH-1:0] mode;
        begin
            if (mode == `ASR_MODE_PAR_INDEP) begin
                startsSecond = 1'h1;
            end else begin
                startsSecond = 1'h0;
            end
        end
    endfunction

    // Limit source drives the pair high on over-limit with no under-limit and low otherwise,
    // as a generator would, with the complement on the second output.
    function [`ASR_PAIR_WIDTH-1:0] pairValue;
        input [`ASR_SRC_WIDTH-1:0] sel;
        input [`ASR_PAIR_WIDTH-1:0] gen;
        input pin;
        input tmr;
        input over;
        input under;
        begin
            if (sel == `ASR_SRC_GPIO) begin
                pairValue = {~pin, pin};
            end else if (sel == `ASR_SRC_TIMER) begin
                pairValue = {~tmr, tmr};
            end else if (sel == `ASR_SRC_LIMIT) begin
                if (over & ~under) begin
                    pairValue = `ASR_PAIR_HIGH;
                end else begin
                    pairValue = `ASR_PAIR_LOW;
                end
            end else begin
                pairValue = gen;
            end
        end
    endfunction

    // ------------------------------------------------------------------------
    // Control decode
    // ------------------------------------------------------------------------
    wire reloadSel = routeCtl[`ASR_CTL_RELOAD_BIT]; // RULE_06
    wire masterEn = routeCtl[`ASR_CTL_MASTER_EN_BIT]; // RULE_06
    wire secondEn = routeCtl[`ASR_CTL_SECOND_EN_BIT]; // RULE_06
    wire [`ASR_PAIRS-1:0] gpioSync;

    asr_sync2 #(
        .WIDTH(`ASR_PAIRS)
    ) u_gpio_sync (
        .clock(clock),
        .rst_n(rst_n),
        .asyncIn(gpioPinIn),
        .syncOut(gpioSync)
    );

    // ------------------------------------------------------------------------
    // Timer channel 3 input path
    // ------------------------------------------------------------------------
    // The selection is a plain mux so the timer sees the pulse in its own cycle.
    assign timerCh3In = reloadSel ? modReloadPulse : timerCh3OrdinaryIn; // RULE_01 RULE_09

    // ------------------------------------------------------------------------
    // Converter triggers
    // ------------------------------------------------------------------------
    wire masterTrig = masterEn & timerCh3Out; // RULE_02
    wire secondTrig = secondEn & timerCh2Out; // RULE_03

    reg masterTrig_reg;
    reg secondTrig_reg;
    reg convAStart_reg;
    reg convBStart_reg;

    reg masterTrig_next;
    reg secondTrig_next;
    reg convAStart_next;
    reg convBStart_next;

    // The secondary trigger can add a start of converter B to what the master gives.
    always @* begin
        masterTrig_next = masterTrig; // RULE_02
        secondTrig_next = secondTrig; // RULE_03
        convAStart_next = masterTrig & startsBoth(convMode); // RULE_04
        convBStart_next = masterTrig & startsBoth(convMode); // RULE_04
        if (secondTrig & startsSecond(convMode)) begin
            convBStart_next = 1'h1; // RULE_05
        end
    end

    // ------------------------------------------------------------------------
    // Trigger and start strobe registers
    // ------------------------------------------------------------------------
    // Each strobe lasts as many clocks as the timer output that causes it.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin // RULE_08
            masterTrig_reg <= `ASR_TRIG_RESET;
        end else begin
            masterTrig_reg <= masterTrig_next; // RULE_02
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin // RULE_08
            secondTrig_reg <= `ASR_TRIG_RESET;
        end else begin
            secondTrig_reg <= secondTrig_next; // RULE_03
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin // RULE_08
            convAStart_reg <= `ASR_TRIG_RESET;
        end else begin
            convAStart_reg <= convAStart_next; // RULE_04
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin // RULE_08
            convBStart_reg <= `ASR_TRIG_RESET;
        end else begin
            convBStart_reg <= convBStart_next; // RULE_04 RULE_05
        end
    end

    assign masterConvTrigger = masterTrig_reg;
    assign secondaryConvTrigger = secondTrig_reg;
    assign converterAStart = convAStart_reg;
    assign converterBStart = convBStart_reg;

    // ------------------------------------------------------------------------
    // Modulator output pair source selection
    // ------------------------------------------------------------------------
    // The pin level comes through the synchroniser, two clocks behind the rest.
    genvar p;
    generate
        for (p = 0; p < `ASR_PAIRS; p = p + 1) begin : g_pair
            wire [`ASR_SRC_WIDTH-1:0] srcSel;
            wire [`ASR_PAIR_WIDTH-1:0] pair_next;
            reg [`ASR_PAIR_WIDTH-1:0] pair_reg;

            assign srcSel = pairSrcSel[`ASR_SRC_WIDTH*p +: `ASR_SRC_WIDTH];
            assign pair_next = pairValue(srcSel,
                generatorOut[`ASR_PAIR_WIDTH*p +: `ASR_PAIR_WIDTH], gpioSync[p],
                timerPairOut[p], converterOverLimit[p], converterUnderLimit[p]); // RULE_07

            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin // RULE_08
                    pair_reg <= `ASR_PAIR_RESET;
                end else begin
                    pair_reg <= pair_next; // RULE_07
                end
            end

            assign modOut[`ASR_PAIR_WIDTH*p +: `ASR_PAIR_WIDTH] = pair_reg;
        end
    endgenerate

endmodule

// [verification/asr_trigger_router_sva.sv]
/* Port assertions for the trigger router.
   Assumes one clock domain and a bind into asr_trigger_router. */
`timescale 1ns/1ps
`include "asr_trigger_consts.vh"
module asr_router_sva (
    input wire clock,
    input wire rst_n,
    input wire [`ASR_CTL_WIDTH-1:0] routeCtl,
    input wire [`ASR_MODE_WIDTH-1:0] convMode,
    input wire modReloadPulse,
    input wire timerCh3OrdinaryIn,
    input wire timerCh2Out,
    input wire timerCh3Out,
    input wire timerCh3In,
    input wire masterConvTrigger,
    input wire secondaryConvTrigger,
    input wire converterAStart,
    input wire converterBStart
);
    wire mFire = routeCtl[1] && timerCh3Out;
    wire sFire = routeCtl[2] && timerCh2Out;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_reload_path: assert property (routeCtl[0] |-> timerCh3In == modReloadPulse)
        else $error("reload path");
    a_ordinary_path: assert property (!routeCtl[0] |-> timerCh3In == timerCh3OrdinaryIn)
        else $error("ordinary path");
    a_master_fire: assert property (mFire |=> masterConvTrigger) else $error("master");
    a_master_gate: assert property (!routeCtl[1] |=> !masterConvTrigger)
        else $error("master gate");
    a_second_fire: assert property (sFire |=> secondaryConvTrigger) else $error("second");
    a_both_start: assert property (mFire && convMode <= `ASR_MODE_PARALLEL |=>
        converterAStart && converterBStart) else $error("both start");
    a_b_only: assert property (sFire && convMode == `ASR_MODE_PAR_INDEP |=>
        converterBStart && !converterAStart) else $error("B only");
    a_none_start: assert property (convMode == 2'h3 |=>
        !converterAStart && !converterBStart) else $error("mode 3 start");
endmodule
bind asr_trigger_router asr_router_sva u_sva (.clock, .rst_n, .routeCtl, .convMode,
    .modReloadPulse, .timerCh3OrdinaryIn, .timerCh2Out, .timerCh3Out, .timerCh3In,
    .masterConvTrigger, .secondaryConvTrigger, .converterAStart, .converterBStart);

// [verification/asr_timer_model.sv]
/* Timer module A stand-in: channel 3 echoes its input, channel 2 follows a drive.
   Assumes the router feeds channel 3 input combinationally. */
`timescale 1ns/1ps
module asr_timer_model (
    input wire timerCh3In,
    input wire ch2Drive,
    output wire timerCh2Out,
    output wire timerCh3Out
);
    assign timerCh3Out = timerCh3In;
    assign timerCh2Out = ch2Drive;
endmodule

// [verification/tb_adc_sync_trigger_routing.sv]
/* Random bench with a mid-run reset for the trigger router.
   Assumes the checker is bound in and the constants header is on the include path. */
`timescale 1ns/1ps
`include "asr_trigger_consts.vh"
module tb_adc_sync_trigger_routing;
    reg clock = 1'h0, rst_n = 1'h0, modReloadPulse = 1'h0, timerCh3OrdinaryIn = 1'h0;
    reg ch2Drive = 1'h0, valid = 1'h0, m, s;
    reg [`ASR_CTL_WIDTH-1:0] routeCtl = 4'h0;
    reg [1:0] convMode = 2'h0;
    reg [5:0] pairSrcSel = 6'h0, generatorOut = 6'h0, e;
    reg [2:0] converterOverLimit = 3'h0, converterUnderLimit = 3'h0, gpioPinIn = 3'h0;
    reg [2:0] timerPairOut = 3'h0, g1 = 3'h0, g2 = 3'h0, g3 = 3'h0;
    wire timerCh2Out, timerCh3Out, timerCh3In, masterConvTrigger, secondaryConvTrigger;
    wire converterAStart, converterBStart;
    wire [5:0] modOut;
    integer seed = 32'h3D70B3E9, failures = 0, n_checks = 0, i, p;
    always #50 clock = ~clock;
    asr_trigger_router dut (.clock, .rst_n, .routeCtl, .convMode, .pairSrcSel, .modReloadPulse,
        .timerCh3OrdinaryIn, .timerCh2Out, .timerCh3Out, .converterOverLimit,
        .converterUnderLimit, .gpioPinIn, .timerPairOut, .generatorOut, .timerCh3In,
        .masterConvTrigger, .secondaryConvTrigger, .converterAStart, .converterBStart, .modOut);
    asr_timer_model partner (.timerCh3In, .ch2Drive, .timerCh2Out, .timerCh3Out);
    task check(input [63:0] nm, input [5:0] seen, input [5:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function [1:0] pexp(input [1:0] sel, input [1:0] gen, input pin, tmr, over, under);
        case (sel)
            `ASR_SRC_GENERATOR: pexp = gen;
            `ASR_SRC_GPIO: pexp = {~pin, pin};
            `ASR_SRC_TIMER: pexp = {~tmr, tmr};
            default: pexp = (over & ~under) ? 2'h1 : 2'h2;
        endcase
    endfunction
    task end_sim;
        $display("Checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clock);
        rst_n = 1'h1;
        for (i = 0; i < 400; i = i + 1) begin
            @(negedge clock);
            if (valid) begin
                m = routeCtl[1] & (routeCtl[0] ? modReloadPulse : timerCh3OrdinaryIn);
                s = routeCtl[2] & ch2Drive;
                check("master", masterConvTrigger, m);
                check("second", secondaryConvTrigger, s);
                check("startA", converterAStart, m & (convMode < 2'h2));
                check("startB", converterBStart,
                    m & (convMode < 2'h2) | s & (convMode == 2'h2));
                for (p = 0; p < 3; p = p + 1)
                    e[2*p +: 2] = pexp(pairSrcSel[2*p +: 2], generatorOut[2*p +: 2], g3[p],
                        timerPairOut[p], converterOverLimit[p], converterUnderLimit[p]);
                check("modOut", modOut, e);
            end
            if (i == 200) begin
                rst_n = 1'h0;
                #1 check("reset", modOut | {masterConvTrigger, secondaryConvTrigger,
                    converterAStart, converterBStart}, 6'h0);
                @(negedge clock);
                rst_n = 1'h1;
                // The release edge samples the pin levels that are still applied.
                {g3, g2, g1} = {6'h0, gpioPinIn};
                valid = 1'h0;
            end else begin
                {routeCtl, convMode, pairSrcSel} = $random(seed);
                {modReloadPulse, timerCh3OrdinaryIn, ch2Drive} = $random(seed);
                {converterOverLimit, converterUnderLimit, gpioPinIn} = $random(seed);
                {timerPairOut, generatorOut} = $random(seed);
                // Pins reach the pair three edges after they are applied.
                {g3, g2, g1} = {g2, g1, gpioPinIn};
                if (i < 4)
                    {routeCtl, convMode} = {4'h7, i[1:0]};
                valid = 1'h1;
                #1 check("ch3In", timerCh3In,
                    routeCtl[0] ? modReloadPulse : timerCh3OrdinaryIn);
            end
        end
        end_sim;
    end
endmodule
